// ==== serial_id_tag.sv ====
// device end: id rom, command levels, add-only memory and programming detect
//
// Overview of operation
// [R1] 64-bit id: family, 48-bit serial, crc
// [R2] crc polynomial x8+x5+x4+1, shift accumulator
// [R3] crc starts zero, family lsb first
// [R4] checker shifting stored crc gets zero
// [R5] memory functions locked until rom sequence
// [R6] master starts with one of four rom commands
// [R7] five memory commands after rom success
// [R8] every byte travels lsb first
// [R9] programming only clears ones to zeros
// [R10] programming voltage raises internal flag
// [R11] commands at logic level, then programming pulse
// [R12] 1024 bits as four 256-bit pages
// [R13] protected page refuses programming
// [R14] rom commands select and discover devices
// [R15] master sends command then two address bytes
// [R16] read header answered with its crc
// [R17] reset pulse aborts, back to rom level
`timescale 1ns/10ps
module serial_id_tag
	import id_link_pkg::*;
#(
	parameter logic [7:0] FAMILY = 8'h5a,                // arbitrary value
	parameter logic [47:0] SERIAL = 48'h0000_1234_5678   // arbitrary value
)(
	input wire logic clock,
	input wire logic nrst,
	sw_link_if.device lnk,
	output logic prog_detect,
	output logic mem_access
);
	import id_link_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef enum logic [3:0] {ST_IDLE, ST_ROMCMD, ST_ROMREAD, ST_MATCH, ST_SEARCH, ST_MEMCMD, ST_ADDR,
		ST_HCRC, ST_RDATA, ST_ECRC, ST_ONES, ST_WDATA, ST_WCRC, ST_PROG, ST_VERIFY} tag_state_t;

	localparam int MA_W = $clog2(MEM_BYTES);
	localparam int SA_W = $clog2(STAT_BYTES);
	localparam logic [63:0] ID = {id_crc({SERIAL, FAMILY}), SERIAL, FAMILY}; // R1 R3

	typedef struct packed {
		tag_state_t st;
		logic s1, s2, s3;
		logic v1, v2, v3;
		logic [15:0] low_cnt;
		logic [15:0] slot_cnt;
		logic [15:0] pres_cnt;
		logic in_slot;
		logic pres_arm;
		logic oe_n;
		logic out;
		logic prog_flag;
		logic mem_ok;
		logic [6:0] bit_cnt;
		logic [1:0] phase;
		logic [7:0] sr;
		logic [7:0] cmd;
		logic [7:0] crc;
		logic [15:0] addr;
		logic [MEM_BYTES-1:0][7:0] mem;
		logic [STAT_BYTES-1:0][7:0] stat;
	} tag_reg_t;

	tag_reg_t q;
	tag_reg_t d;
	logic is_stat;
	logic last;
	logic in_range;
	logic [7:0] cur;
	logic [7:0] nb;
	logic txb;
	logic rx;
	logic samp;
	logic idb;
	logic byte_end;
	logic [7:0] crc_src;
	logic [7:0] byte_src;
	logic [7:0] crc_nx;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	assign is_stat = (q.cmd == MEM_RDSTAT) || (q.cmd == MEM_WRSTAT);
	assign last = is_stat ? (q.addr == STAT_LAST) : (q.addr == MEM_LAST);
	assign in_range = is_stat ? (q.addr <= STAT_LAST) : (q.addr <= MEM_LAST); // R12
	assign cur = is_stat ? q.stat[q.addr[SA_W-1:0]] : q.mem[q.addr[MA_W-1:0]];
	assign rx = q.s2;
	assign nb = {rx, q.sr[7:1]};   // R8
	assign samp = q.in_slot && (q.slot_cnt == DSAMP_CYC);
	assign idb = ID[q.bit_cnt[5:0]];
	assign byte_end = (q.bit_cnt[2:0] == 3'h7);

	// header crc starts from zero at the command byte
	assign crc_src = (q.st == ST_MEMCMD) ? 8'h00 : q.crc;
	assign byte_src = (q.st == ST_RDATA) ? cur : nb;

	crc8_byte u_crc (
		.crc_i(crc_src),
		.data_i(byte_src),
		.crc_o(crc_nx)
	);

	// bit answered in the current slot, one means leave the wire alone
	always_comb begin
		case (q.st)
			ST_ROMREAD: txb = idb; // R14
			ST_SEARCH: txb = (q.phase == 2'h0) ? idb : ((q.phase == 2'h1) ? !idb : 1'b1); // R14
			ST_HCRC, ST_ECRC, ST_WCRC: txb = q.crc[q.bit_cnt[2:0]]; // R16 R8
			ST_RDATA, ST_VERIFY: txb = cur[q.bit_cnt[2:0]]; // R8
			default: txb = 1'b1;
		endcase
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		d = q;
		d.s1 = lnk.dq;
		d.s2 = q.s1;
		d.s3 = q.s2;
		d.v1 = lnk.vpp;
		d.v2 = q.v1;
		d.v3 = q.v2;
		d.prog_flag = q.v2; // R10
		d.out = 1'b0;
		d.low_cnt = q.s2 ? 16'h0000 : ((q.low_cnt == 16'hffff) ? q.low_cnt : q.low_cnt + 16'h0001);

		// presence after reset, otherwise slot timing
		if (q.pres_arm) begin
			if (q.s2 || (q.pres_cnt != 16'h0000)) begin
				d.pres_cnt = q.pres_cnt + 16'h0001;
			end
			if (q.pres_cnt == PDLY_CYC) begin
				d.oe_n = 1'b0;
			end
			if (q.pres_cnt == PEND_CYC) begin
				d.oe_n = 1'b1;
				d.pres_arm = 1'b0;
			end
		end else if (q.in_slot) begin
			d.slot_cnt = q.slot_cnt + 16'h0001;
			if (q.slot_cnt == HOLD_CYC) begin
				d.oe_n = 1'b1;
				d.in_slot = 1'b0;
			end
		end else if (q.s3 && !q.s2) begin
			d.in_slot = 1'b1;
			d.slot_cnt = 16'h0000;
			d.oe_n = txb;
		end

		// one bit per slot at the sample point
		if (samp) begin
			d.sr = nb;
			d.bit_cnt = q.bit_cnt + 7'h01;
			case (q.st)
				ST_ROMCMD: if (byte_end) begin // R6
					d.bit_cnt = 7'h00;
					case (nb)
						ROM_READ: d.st = ST_ROMREAD;
						ROM_MATCH: d.st = ST_MATCH;
						ROM_SEARCH: d.st = ST_SEARCH;
						ROM_SKIP: d.st = ST_MEMCMD;
						default: d.st = ST_IDLE;
					endcase
				end
				ST_ROMREAD: if (q.bit_cnt == 7'h3f) begin
					d.bit_cnt = 7'h00;
					d.st = ST_MEMCMD;
				end
				ST_MATCH: if (rx != idb) begin // R14
					d.st = ST_IDLE;
				end else if (q.bit_cnt == 7'h3f) begin
					d.bit_cnt = 7'h00;
					d.st = ST_MEMCMD;
				end
				ST_SEARCH: begin // R14
					d.bit_cnt = q.bit_cnt;
					d.phase = q.phase + 2'h1;
					if (q.phase == 2'h2) begin
						d.phase = 2'h0;
						d.bit_cnt = q.bit_cnt + 7'h01;
						if (rx != idb) begin
							d.st = ST_IDLE;
						end else if (q.bit_cnt == 7'h3f) begin
							d.bit_cnt = 7'h00;
							d.st = ST_MEMCMD;
						end
					end
				end
				ST_MEMCMD: if (byte_end) begin // R5 R7
					d.bit_cnt = 7'h00;
					d.cmd = nb;
					d.crc = crc_nx;
					if (nb == MEM_RD || nb == MEM_RDSTAT || nb == MEM_RDCRC || nb == MEM_WR || nb == MEM_WRSTAT) begin
						d.st = ST_ADDR;
					end else begin
						d.st = ST_IDLE;
					end
				end
				ST_ADDR: begin // R15
					d.addr = {rx, q.addr[15:1]};
					if (byte_end) begin
						d.crc = crc_nx; // R16
					end
					if (q.bit_cnt == 7'h0f) begin
						d.bit_cnt = 7'h00;
						d.st = (q.cmd == MEM_WR || q.cmd == MEM_WRSTAT) ? ST_WDATA : ST_HCRC;
					end
				end
				ST_HCRC: if (byte_end) begin // R16
					d.bit_cnt = 7'h00;
					d.crc = 8'h00;
					d.st = in_range ? ST_RDATA : ST_ONES;
				end
				ST_RDATA: if (byte_end) begin
					d.bit_cnt = 7'h00;
					d.crc = crc_nx;
					if (last) begin
						d.st = ST_ECRC;
					end else begin
						d.addr = q.addr + 16'h0001;
					end
				end
				ST_ECRC: if (byte_end) begin
					d.st = ST_ONES;
				end
				ST_WDATA: if (byte_end) begin
					d.bit_cnt = 7'h00;
					d.crc = crc_nx;
					d.st = in_range ? ST_WCRC : ST_ONES;
				end
				// crc slots must not overwrite the loaded data byte
				ST_WCRC: begin // R11
					d.sr = q.sr;
					if (byte_end) begin
						d.bit_cnt = 7'h00;
						d.st = ST_PROG;
					end
				end
				ST_VERIFY: if (byte_end) begin
					d.bit_cnt = 7'h00;
					d.crc = 8'h00;
					d.addr = q.addr + 16'h0001;
					d.st = last ? ST_ONES : ST_WDATA;
				end
				ST_PROG: d.bit_cnt = q.bit_cnt;
				default: d.bit_cnt = q.bit_cnt;
			endcase
		end

		// burn the loaded byte on the rising edge of the programming pulse
		if ((q.st == ST_PROG) && q.v2 && !q.v3) begin // R11
			if (is_stat) begin
				d.stat[q.addr[SA_W-1:0]] = q.stat[q.addr[SA_W-1:0]] & q.sr; // R9
			end else if (q.stat[WP_BYTE][q.addr[PAGE_LSB +: 2]]) begin // R13
				d.mem[q.addr[MA_W-1:0]] = q.mem[q.addr[MA_W-1:0]] & q.sr; // R9 R12
			end
			d.bit_cnt = 7'h00;
			d.st = ST_VERIFY;
		end

		// a long low aborts everything and arms presence
		if (q.low_cnt == RSTDET_CYC) begin // R17
			d.st = ST_ROMCMD;
			d.bit_cnt = 7'h00;
			d.phase = 2'h0;
			d.in_slot = 1'b0;
			d.oe_n = 1'b1;
			d.pres_arm = 1'b1;
			d.pres_cnt = 16'h0000;
			d.crc = 8'h00;
		end
		d.mem_ok = !(d.st inside {ST_IDLE, ST_ROMCMD, ST_ROMREAD, ST_MATCH, ST_SEARCH}); // R5
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			q <= '0;
			q.s1 <= 1'b1;
			q.s2 <= 1'b1;
			q.s3 <= 1'b1;
			q.oe_n <= 1'b1;
			q.mem <= '1;
			q.stat <= '1;
		end else begin
			q <= d;
		end
	end

	assign lnk.dev_dq_oe_n = q.oe_n;
	assign lnk.dev_dq_out = q.out;
	assign prog_detect = q.prog_flag;
	assign mem_access = q.mem_ok;
endmodule

// ==== id_link_pkg.sv ====
// shared constants, types and crc helpers for both ends of the single-wire id link
package id_link_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_NS = 100;

	// least time in ns to whole clock cycles, rounded up, never below one
	function automatic logic [15:0] cyc_up(input int t_ns);
		int c;
		c = (t_ns + CLK_NS - 1) / CLK_NS;
		return (c < 1) ? 16'h0001 : 16'(c);
	endfunction

	localparam int T_LOW1_NS = 200;     // master low time for a one or a read slot
	localparam int T_LOW0_NS = 1000;    // master low time for a zero
	localparam int T_HSAMP_NS = 800;    // master sample point after its fall
	localparam int T_SLOT_NS = 2000;    // whole slot length
	localparam int T_DSAMP_NS = 600;    // device sample point after it sees the fall
	localparam int T_HOLD_NS = 1000;    // device hold of a zero answer
	localparam int T_RST_NS = 5000;     // master reset pulse
	localparam int T_RSTDET_NS = 4000;  // low time the device takes as reset
	localparam int T_PDLY_NS = 100;     // device wait before presence
	localparam int T_PRES_NS = 1500;    // presence pulse length
	localparam int T_PSAMP_NS = 1000;   // master presence sample after release
	localparam int T_REC_NS = 2500;     // reset recovery after release
	localparam int T_PROG_NS = 48000;   // programming pulse length

	localparam logic [15:0] LOW1_CYC = cyc_up(T_LOW1_NS);
	localparam logic [15:0] LOW0_CYC = cyc_up(T_LOW0_NS);
	localparam logic [15:0] HSAMP_CYC = cyc_up(T_HSAMP_NS);
	localparam logic [15:0] SLOT_CYC = cyc_up(T_SLOT_NS);
	localparam logic [15:0] DSAMP_CYC = cyc_up(T_DSAMP_NS);
	localparam logic [15:0] HOLD_CYC = cyc_up(T_HOLD_NS);
	localparam logic [15:0] RST_CYC = cyc_up(T_RST_NS);
	localparam logic [15:0] RSTDET_CYC = cyc_up(T_RSTDET_NS);
	localparam logic [15:0] PDLY_CYC = cyc_up(T_PDLY_NS);
	localparam logic [15:0] PEND_CYC = cyc_up(T_PDLY_NS + T_PRES_NS);
	localparam logic [15:0] PSAMP_AT = cyc_up(T_RST_NS + T_PSAMP_NS);
	localparam logic [15:0] REC_AT = cyc_up(T_RST_NS + T_REC_NS);
	localparam logic [15:0] PROG_CYC = cyc_up(T_PROG_NS);

	// ------------------------------------------------------------
	// commands
	// ------------------------------------------------------------
	localparam logic [7:0] ROM_READ = 8'h33;
	localparam logic [7:0] ROM_MATCH = 8'h55;
	localparam logic [7:0] ROM_SEARCH = 8'hf0;
	localparam logic [7:0] ROM_SKIP = 8'hcc;
	localparam logic [7:0] MEM_RD = 8'hf0;
	localparam logic [7:0] MEM_RDSTAT = 8'haa;
	localparam logic [7:0] MEM_RDCRC = 8'hc3;
	localparam logic [7:0] MEM_WR = 8'h0f;
	localparam logic [7:0] MEM_WRSTAT = 8'h55;

	// ------------------------------------------------------------
	// memory layout
	// ------------------------------------------------------------
	localparam int MEM_BYTES = 128;
	localparam int STAT_BYTES = 8;
	localparam logic [15:0] MEM_LAST = 16'h007f;
	localparam logic [15:0] STAT_LAST = 16'h0007;
	localparam int PAGE_LSB = 5;        // page number field in a byte address
	localparam int WP_BYTE = 0;         // status byte holding page protect bits
	localparam logic [7:0] CRC_POLY = 8'h8c;  // x^8+x^5+x^4+1, reflected

	// host operations
	typedef enum logic [1:0] {OP_RESET, OP_WRITE, OP_READ, OP_PROG} host_op_t;

	// one bit into the shift-register crc accumulator
	function automatic logic [7:0] crc8_bit(input logic [7:0] crc, input logic b);
		logic fb;
		fb = crc[0] ^ b;
		return (crc >> 1) ^ (fb ? CRC_POLY : 8'h00);
	endfunction

	// crc of the first 56 id bits, lsb of family code first
	function automatic logic [7:0] id_crc(input logic [55:0] bits);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < 56; i++) begin
			c = crc8_bit(c, bits[i]);
		end
		return c;
	endfunction

endpackage

// ==== sw_link_if.sv ====
// single data wire with pull-up plus programming pulse line
`timescale 1ns/10ps
interface sw_link_if;
	logic dq;
	logic host_dq_out;
	logic host_dq_oe_n;
	logic dev_dq_out;
	logic dev_dq_oe_n;
	logic vpp;

	// wired-and with pull-up: low only where an end drives a zero
	assign dq = !((!host_dq_oe_n && !host_dq_out) || (!dev_dq_oe_n && !dev_dq_out));

	modport device (input dq, input vpp, output dev_dq_out, output dev_dq_oe_n);
	modport host (input dq, output host_dq_out, output host_dq_oe_n, output vpp);
endinterface

// ==== crc8_byte.sv ====
// eight crc steps over one byte, lsb first
`timescale 1ns/10ps
module crc8_byte
	import id_link_pkg::*;
(
	input wire logic [7:0] crc_i,
	input wire logic [7:0] data_i,
	output logic [7:0] crc_o
);
	// unrolled shift of all eight bits
	always_comb begin
		logic [7:0] c;
		c = crc_i;
		for (int i = 0; i < 8; i++) begin
			c = crc8_bit(c, data_i[i]);
		end
		crc_o = c;
	end
endmodule

// ==== link_master.sv ====
// host end: resets, byte slots and programming pulses with a running crc check
`timescale 1ns/10ps
module link_master
	import id_link_pkg::*;
(
	input wire logic clock,
	input wire logic nrst,
	sw_link_if.host lnk,
	input wire logic op_valid,
	input wire id_link_pkg::host_op_t op,
	input wire logic [7:0] op_data,
	input wire logic crc_clear,
	output logic busy,
	output logic done,
	output logic [7:0] rd_data,
	output logic presence,
	output logic [7:0] crc_acc,
	output logic crc_ok
);
	import id_link_pkg::*;

	typedef enum logic [1:0] {H_IDLE, H_RST, H_SLOT, H_PROG} host_state_t;

	typedef struct packed {
		host_state_t st;
		logic s1, s2;
		logic oe_n;
		logic out;
		logic vpp;
		logic [15:0] cnt;
		logic [2:0] bit_cnt;
		logic [7:0] tx;
		logic [7:0] sr;
		logic busy;
		logic done;
		logic [7:0] rd_data;
		logic presence;
		logic [7:0] crc;
		logic crc_ok;
	} host_reg_t;

	host_reg_t q;
	host_reg_t d;
	logic [7:0] crc_nx;

	// crc over each finished byte as seen on the wire
	crc8_byte u_crc (
		.crc_i(q.crc),
		.data_i(q.sr),
		.crc_o(crc_nx)
	);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		d = q;
		d.s1 = lnk.dq;
		d.s2 = q.s1;
		d.out = 1'b0;
		d.done = 1'b0;
		d.cnt = q.cnt + 16'h0001;
		case (q.st)
			H_IDLE: begin
				d.cnt = 16'h0000;
				if (crc_clear) begin // R4
					d.crc = 8'h00;
					d.crc_ok = 1'b1;
				end
				if (op_valid) begin
					d.busy = 1'b1;
					d.bit_cnt = 3'h0;
					d.tx = (op == OP_READ) ? 8'hff : op_data;
					case (op)
						OP_RESET: begin
							d.st = H_RST;
							d.oe_n = 1'b0;
						end
						OP_PROG: begin // R11
							d.st = H_PROG;
							d.vpp = 1'b1;
						end
						default: begin
							d.st = H_SLOT;
							d.oe_n = 1'b0;
						end
					endcase
				end
			end
			H_RST: begin // R17
				if (q.cnt == RST_CYC - 16'h0001) begin
					d.oe_n = 1'b1;
				end
				if (q.cnt == PSAMP_AT) begin
					d.presence = !q.s2;
				end
				if (q.cnt == REC_AT) begin
					d.st = H_IDLE;
					d.busy = 1'b0;
					d.done = 1'b1;
				end
			end
			H_SLOT: begin
				if (q.cnt == (q.tx[0] ? LOW1_CYC : LOW0_CYC) - 16'h0001) begin
					d.oe_n = 1'b1;
				end
				if (q.cnt == HSAMP_CYC) begin
					d.sr = {q.s2, q.sr[7:1]}; // R8
				end
				if (q.cnt == SLOT_CYC - 16'h0001) begin
					d.cnt = 16'h0000;
					d.tx = {1'b1, q.tx[7:1]}; // R8
					d.bit_cnt = q.bit_cnt + 3'h1;
					if (q.bit_cnt == 3'h7) begin
						d.st = H_IDLE;
						d.busy = 1'b0;
						d.done = 1'b1;
						d.rd_data = q.sr;
						d.crc = crc_nx; // R2 R3
						d.crc_ok = (crc_nx == 8'h00); // R4 R16
					end else begin
						d.oe_n = 1'b0;
					end
				end
			end
			H_PROG: if (q.cnt == PROG_CYC - 16'h0001) begin // R11
				d.vpp = 1'b0;
				d.st = H_IDLE;
				d.busy = 1'b0;
				d.done = 1'b1;
			end
			default: d.st = H_IDLE;
		endcase
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			q <= '0;
			q.s1 <= 1'b1;
			q.s2 <= 1'b1;
			q.oe_n <= 1'b1;
			q.crc_ok <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign lnk.host_dq_oe_n = q.oe_n;
	assign lnk.host_dq_out = q.out;
	assign lnk.vpp = q.vpp;
	assign busy = q.busy;
	assign done = q.done;
	assign rd_data = q.rd_data;
	assign presence = q.presence;
	assign crc_acc = q.crc;
	assign crc_ok = q.crc_ok;
endmodule

// ==== link_asserts.sv ====
// concurrent checks on the single-wire link and the tag status flags
`timescale 1ns/10ps
module link_asserts (
	input wire logic clock,
	input wire logic nrst,
	input wire logic dq,
	input wire logic host_dq_oe_n,
	input wire logic dev_dq_oe_n,
	input wire logic vpp,
	input wire logic prog_detect,
	input wire logic mem_access
);
	// ------------------------------------------------------------
	// wire watchers
	// ------------------------------------------------------------
	logic [7:0] low_q;
	logic [7:0] fall_q;
	logic dq_q;

	// low time of the wire, and falls seen since the last long low
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			low_q <= 8'h00;
			fall_q <= 8'h00;
			dq_q <= 1'b1;
		end else begin
			low_q <= dq ? 8'h00 : low_q + {7'h00, low_q != 8'hff};
			fall_q <= (low_q >= 8'h28) ? 8'h00 : fall_q + {7'h00, dq_q && !dq && fall_q != 8'hff};
			dq_q <= dq;
		end
	end

	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);

	a_flag_rises: assert property ($rose(vpp) |-> ##[2:4] prog_detect)
		else $error("programming flag did not follow the pulse");
	a_flag_drops: assert property ($fell(vpp) |-> ##[2:4] !prog_detect)
		else $error("programming flag stayed after the pulse");
	a_flag_needs_vpp: assert property (!vpp [*5] |-> !prog_detect)
		else $error("programming flag without a pulse");
	a_line_quiet_prog: assert property (vpp |-> host_dq_oe_n && dev_dq_oe_n)
		else $error("data line driven during the programming pulse");
	a_prog_needs_access: assert property ($rose(vpp) |-> mem_access)
		else $error("programming pulse outside the memory level");
	a_access_after_cmd: assert property ($rose(mem_access) |-> fall_q >= 8'h08)
		else $error("memory level reached without a full command");
	a_reset_locks: assert property (low_q == 8'h30 |-> !mem_access)
		else $error("memory level kept through a reset pulse");
	a_access_falls: assert property ($fell(mem_access) |-> low_q >= 8'h28)
		else $error("memory level left without a reset pulse");
	a_dev_quiet_reset: assert property (low_q > 8'h10 |-> dev_dq_oe_n)
		else $error("tag drives the line during a reset pulse");
endmodule

// ==== tb.sv ====
// self-checking bench: tag and host joined over the single-wire link
`timescale 1ns/10ps
module tb;
	import id_link_pkg::*;
	localparam logic [7:0] FAM = 8'h3c;                // arbitrary value
	localparam logic [47:0] SER = 48'h0000_a5c3_9e71;  // arbitrary value
	logic clock;
	logic nrst;
	logic op_valid;
	host_op_t op;
	logic [7:0] op_data;
	logic crc_clear;
	logic busy;
	logic done;
	logic [7:0] rd_data;
	logic presence;
	logic [7:0] crc_acc;
	logic crc_ok;
	logic prog_detect;
	logic mem_access;
	logic [7:0] rnd;
	int error_cnt;
	int n_checks;

	// ------------------------------------------------------------
	// both ends and the checker
	// ------------------------------------------------------------
	sw_link_if sw_link_if_i();
	serial_id_tag #(.FAMILY(FAM), .SERIAL(SER)) serial_id_tag_i (.clock(clock), .nrst(nrst), .lnk(sw_link_if_i),
		.prog_detect(prog_detect), .mem_access(mem_access));
	link_master link_master_i (.clock(clock), .nrst(nrst), .lnk(sw_link_if_i), .op_valid(op_valid), .op(op),
		.op_data(op_data), .crc_clear(crc_clear), .busy(busy), .done(done), .rd_data(rd_data),
		.presence(presence), .crc_acc(crc_acc), .crc_ok(crc_ok));
	link_asserts link_asserts_i (.clock(clock), .nrst(nrst), .dq(sw_link_if_i.dq),
		.host_dq_oe_n(sw_link_if_i.host_dq_oe_n),
		.dev_dq_oe_n(sw_link_if_i.dev_dq_oe_n), .vpp(sw_link_if_i.vpp), .prog_detect(prog_detect),
		.mem_access(mem_access));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] lfsr(input logic [7:0] r);
		return {r[6:0], r[7] ^ r[5] ^ r[4] ^ r[3]};
	endfunction

	// x^8+x^5+x^4+1 accumulator, one byte lsb first
	function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			c = (c[0] ^ b[i]) ? ((c >> 1) ^ 8'h8c) : (c >> 1);
		end
		return c;
	endfunction

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// one host operation, waits for its done pulse
	task automatic host_op(input host_op_t o, input logic [7:0] d);
		int n;
		@(negedge clock);
		op_valid = 1'b1;
		op = o;
		op_data = d;
		@(negedge clock);
		op_valid = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 1000) begin
			@(negedge clock);
			n++;
		end
		if (n >= 1000) check(8'h00, 8'h01);
	endtask

	task automatic rd(output logic [7:0] b);
		host_op(OP_READ, 8'hff);
		b = rd_data;
	endtask

	task automatic clr();
		@(negedge clock);
		crc_clear = 1'b1;
		@(negedge clock);
		crc_clear = 1'b0;
	endtask

	// reset, skip selection, then a three-byte memory header
	task automatic header(input logic [7:0] cmd, input logic [7:0] lo, output logic [7:0] c);
		host_op(OP_RESET, 8'h00);
		check({7'h00, presence}, 8'h01);
		host_op(OP_WRITE, ROM_SKIP);
		check({7'h00, mem_access}, 8'h01);
		clr();
		host_op(OP_WRITE, cmd);
		host_op(OP_WRITE, lo);
		host_op(OP_WRITE, 8'h00);
		c = crc_step(crc_step(crc_step(8'h00, cmd), lo), 8'h00);
	endtask

	// header, data byte, crc check, pulse, read back
	task automatic prog_byte(input logic [7:0] cmd, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
		logic [7:0] c;
		logic [7:0] b;
		header(cmd, a, c);
		host_op(OP_WRITE, d);
		rd(b);
		check(b, crc_step(c, d));
		host_op(OP_PROG, 8'h00);
		rd(b);
		check(b, e);
	endtask

	// status read attempted without a selection command
	task automatic locked();
		logic [7:0] b;
		host_op(OP_RESET, 8'h00);
		check({7'h00, mem_access}, 8'h00);
		check({7'h00, busy}, 8'h00);
		host_op(OP_WRITE, MEM_RDSTAT);
		host_op(OP_WRITE, 8'h00);
		host_op(OP_WRITE, 8'h00);
		rd(b);
		check(b, 8'hff);
		check({7'h00, mem_access}, 8'h00);
	endtask

	// ------------------------------------------------------------
	// clock, stimulus, watchdog
	// ------------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	initial begin
		#(60000 * 100);
		error_cnt++;
		give_verdict();
	end

	initial begin
		logic [63:0] id;
		logic [7:0] c;
		logic [7:0] b;
		logic [7:0] a2;
		logic [7:0] v2;
		logic [7:0] d1;
		logic [7:0] t;
		logic [7:0] w;
		int k3;
		nrst = 1'b0;
		op_valid = 1'b0;
		op = OP_RESET;
		op_data = 8'h00;
		crc_clear = 1'b0;
		rnd = 8'h5a;
		error_cnt = 0;
		n_checks = 0;
		repeat (5) @(negedge clock);
		nrst = 1'b1;
		// memory refused before selection, and after an aborted header
		locked();
		header(MEM_RDSTAT, 8'h00, c);
		locked();
		// identity read: family, serial, then crc of the first 56 bits
		c = crc_step(8'h00, FAM);
		for (int i = 0; i < 6; i++) c = crc_step(c, SER[8*i+:8]);
		id = {c, SER, FAM};
		host_op(OP_RESET, 8'h00);
		host_op(OP_WRITE, ROM_READ);
		clr();
		for (int i = 0; i < 8; i++) begin
			rd(b);
			check(b, id[8*i+:8]);
		end
		check({7'h00, crc_ok}, 8'h01);
		check(crc_acc, 8'h00);
		check({7'h00, mem_access}, 8'h01);
		// match with the right identity, then with one wrong bit
		for (int k = 0; k < 2; k++) begin
			host_op(OP_RESET, 8'h00);
			host_op(OP_WRITE, ROM_MATCH);
			for (int i = 0; i < 8; i++) host_op(OP_WRITE, id[8*i+:8] ^ {7'h00, k == 1 && i == 3});
			check({7'h00, mem_access}, {7'h00, k == 0});
		end
		// search: two read slots, then the direction bit, for all 64 bits
		host_op(OP_RESET, 8'h00);
		host_op(OP_WRITE, ROM_SEARCH);
		for (int i = 0; i < 24; i++) begin
			for (int s = 0; s < 8; s++) begin
				k3 = 8 * i + s;
				t[s] = ((k3 % 3) != 2) || id[k3 / 3];
				w[s] = ((k3 % 3) == 1) ? !id[k3 / 3] : id[k3 / 3];
			end
			host_op(OP_WRITE, t);
			check(rd_data, w);
		end
		check({7'h00, mem_access}, 8'h01);
		// read headers answered with their crc, erased content reads ones
		for (int j = 0; j < 3; j++) begin
			rnd = lfsr(rnd);
			header((j == 0) ? MEM_RD : (j == 1) ? MEM_RDSTAT : MEM_RDCRC, rnd & ((j == 1) ? 8'h07 : 8'h7f), c);
			rd(b);
			check(b, c);
			check({7'h00, crc_ok}, 8'h01);
			rd(b);
			check(b, 8'hff);
		end
		// two programmings per page: only ones turn to zeros
		for (int p = 0; p < 4; p++) begin
			rnd = lfsr(rnd);
			a2 = {1'b0, 2'(p), rnd[4:0]};
			d1 = lfsr(rnd);
			rnd = lfsr(d1);
			prog_byte(MEM_WR, a2, d1, d1);
			prog_byte(MEM_WR, a2, rnd, d1 & rnd);
			if (p == 2) v2 = d1 & rnd;
			if (p == 2) b = a2;
		end
		// protect page 2, its bytes then stay, page 3 still programs
		prog_byte(MEM_WRSTAT, 8'h00, 8'hfb, 8'hfb);
		prog_byte(MEM_WR, b, 8'h00, v2);
		prog_byte(MEM_WR, a2, 8'h00, 8'h00);
		give_verdict();
	end
endmodule
